// ===== bench/tcse_partner.sv
`timescale 1ns/100ps
module tcse_partner
(
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic hold_in,
   input wire logic [3:0] width_in,
   output logic ev_out
);
   logic pulse_q = 1'b0;
   // fabric level plus a pulse burst
   assign ev_out = pulse_q | hold_in;
   // widths and gaps of two or more clocks keep levels slower than the timer
   always @(posedge go_in)
   begin
      repeat (3)
      begin
         repeat (width_in) @(negedge clk_in);
         pulse_q <= 1'b1;
         repeat (width_in) @(negedge clk_in);
         pulse_q <= 1'b0;
      end
   end
endmodule

// ===== bench/tcse_sva.sv
`timescale 1ns/100ps
module tcse_sva
   import tcse_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   input wire logic enable_in,
   input wire logic split_enable_bit_in,
   input wire logic run_in_standby_bit_in,
   input wire logic [2:0] prescaler_select_in,
   input wire logic [1:0] command_in,
   input wire logic command_strobe_in,
   input wire logic [1:0] sleep_mode_in,
   input wire logic wr_strobe_in,
   input wire logic [TCSE_NFLAG-1:0] interrupt_enable_in,
   input wire logic [15:0] counter_value_out,
   input wire logic [5:0] waveform_output_out,
   input wire logic [TCSE_NFLAG-1:0] interrupt_flag_out,
   input wire logic [TCSE_NFLAG-1:0] irq_out,
   input wire logic overflow_or_low_underflow_event_out,
   input wire logic high_underflow_out,
   input wire logic [2:0] compare_match_event_out
);
   logic quiet, run8, halt;
   // no command or write; split running at full rate; sleeping without run
   assign quiet = clk_en_in && !command_strobe_in && !wr_strobe_in;
   assign run8 = quiet && enable_in && split_enable_bit_in && prescaler_select_in == 3'h0
      && sleep_mode_in == TCSE_SLEEP_ACTIVE;
   assign halt = quiet && (sleep_mode_in == TCSE_SLEEP_PDOWN
      || (sleep_mode_in == TCSE_SLEEP_STANDBY && !run_in_standby_bit_in));
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ********
   // properties
   // ********
   sequence s_restart;
      clk_en_in && command_strobe_in && command_in == TCSE_CMD_RESTART; endsequence
   sequence s_cleared; counter_value_out == 16'h0000 && waveform_output_out == 6'h00; endsequence
   property p_restart; s_restart |=> s_cleared; endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear");
   property p_reset; clk_en_in && command_strobe_in && command_in == TCSE_CMD_RESET && !enable_in
      |=> counter_value_out == 16'h0000 && interrupt_flag_out == '0; endproperty
   a_reset: assert property (p_reset) else $error("reset command left state");
   property p_irq; $stable(interrupt_enable_in)
      |-> irq_out == (interrupt_flag_out & interrupt_enable_in); endproperty
   a_irq: assert property (p_irq) else $error("request does not follow flag");
   property p_lo; run8 && counter_value_out[7:0] != 8'h00
      |=> counter_value_out[7:0] == $past(counter_value_out[7:0]) - 8'h01; endproperty
   a_lo: assert property (p_lo) else $error("low byte did not count down");
   property p_hi; run8 && counter_value_out[15:8] != 8'h00
      |=> counter_value_out[15:8] == $past(counter_value_out[15:8]) - 8'h01; endproperty
   a_hi: assert property (p_hi) else $error("high byte did not count down");
   property p_high_underflow; high_underflow_out
      |-> $past(split_enable_bit_in) && interrupt_flag_out[TCSE_F_HIGH_UNDERFLOW]; endproperty
   a_high_underflow: assert property (p_high_underflow) else $error("high underflow event out of place");
   property p_evflag; ({compare_match_event_out, overflow_or_low_underflow_event_out}
      & ~interrupt_flag_out[3:0]) == 4'h0; endproperty
   a_evflag: assert property (p_evflag) else $error("event without its flag");
   property p_halt; halt && $past(halt) |=> $stable(counter_value_out); endproperty
   a_halt: assert property (p_halt) else $error("counter moved while halted");
endmodule
bind tcse_timer tcse_sva u_sva (.*);

// ===== bench/tcse_timer_tb_top.sv
`timescale 1ns/100ps
module tcse_timer_tb_top
   import tcse_pkg::*;
;
   logic clk_in = 1'b0;
   logic nrst_in, clk_en_in, enable_in, split_enable_bit_in, run_in_standby_bit_in;
   logic lock_update_bit_in, dir_in, command_strobe_in, wr_strobe_in, wr_hi_byte_in, go, hold;
   logic first_event_input_in, second_event_input_in, count_down_out, mon_on;
   logic first_event_input_enable_in, second_event_input_enable_in;
   logic overflow_or_low_underflow_event_out, high_underflow_out;
   logic [2:0] prescaler_select_in, wr_sel_in, first_event_action_in, second_event_action_in;
   logic [2:0] compare_match_event_out;
   logic [1:0] command_in, sleep_mode_in;
   logic [7:0] wr_data_in;
   logic [TCSE_NFLAG-1:0] flag_clear_in, interrupt_enable_in, interrupt_flag_out, irq_out, obs;
   logic [15:0] counter_value_out, mx;
   logic [5:0] waveform_output_out, wo_acc;
   logic [3:0] width;
   logic [31:0] seed;
   logic [4:0] q[$];
   int error_cnt, check_count, i;
   tcse_timer uut (.*);
   tcse_partner u_ev (.clk_in(clk_in), .go_in(go), .hold_in(hold), .width_in(width),
      .ev_out(first_event_input_in));
   always #50 clk_in = ~clk_in;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // byte-wide writes, low byte first
   task automatic wr16(input logic [2:0] sel, input logic [15:0] d);
      for (int b = 0; b < 2; b++)
      begin
         tick(1);
         {wr_sel_in, wr_hi_byte_in, wr_data_in, wr_strobe_in} = {sel, b[0], d[8*b+:8], 1'b1};
         tick(1);
         wr_strobe_in = 1'b0;
      end
   endtask
   task automatic cmd(input logic [1:0] c);
      tick(1);
      {command_in, command_strobe_in} = {c, 1'b1};
      tick(1);
      command_strobe_in = 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // each event pulse takes the oldest note, sampled once settled
   assign obs = {high_underflow_out, compare_match_event_out, overflow_or_low_underflow_event_out};
   always @(negedge clk_in)
      if (mon_on && obs != 5'h00)
         check(obs, (q.size() > 0) ? q.pop_front() : 16'hffff);
   initial
   begin
      #300000;
      error_cnt++;
      $display("watchdog expired");
      end_sim();
   end
   // ********
   // main sequence
   // ********
   initial
   begin
      {nrst_in, enable_in, split_enable_bit_in, run_in_standby_bit_in, go, hold} = '0;
      {lock_update_bit_in, dir_in, command_strobe_in, wr_strobe_in, wr_hi_byte_in, mon_on} = '0;
      {first_event_input_enable_in, second_event_input_enable_in, second_event_input_in} = '0;
      {prescaler_select_in, wr_sel_in, first_event_action_in, second_event_action_in} = '0;
      {command_in, sleep_mode_in, wr_data_in, flag_clear_in, interrupt_enable_in} = '0;
      {width, wo_acc} = '0;
      {error_cnt, check_count} = '0;
      clk_en_in = 1'b1;
      seed = 32'hdde5_0f2c;
      tick(5);
      nrst_in = 1'b1;
      check(counter_value_out, TCSE_CNT_RST);
      check(interrupt_flag_out, TCSE_FLAG_RST);
      first_event_input_enable_in = 1'b1;
      for (i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         width = 4'h2 + {2'b00, seed[1:0]};
         first_event_action_in = i[2:0];
         cmd(TCSE_CMD_RESET);
         {enable_in, go} = 2'b11;
         tick(40);
         go = 1'b0;
         check(counter_value_out, (i == 2) ? 16'(3 * width) : 16'(3 * (i + 1)));
         enable_in = 1'b0;
      end
      $display("event counting done");
      {first_event_action_in, second_event_action_in} = {TCSE_EVA_UPDOWN, TCSE_EVB_UPDOWN};
      {second_event_input_enable_in, enable_in} = 2'b11;
      for (i = 0; i < 4; i++)
      begin
         {second_event_input_in, hold} = i[1:0];
         tick(4);
         check(count_down_out, i != 0);
      end
      {first_event_action_in, second_event_action_in} = {TCSE_EVA_HIGHLVL, TCSE_EVB_RESTART_HIGH};
      tick(4);
      check(counter_value_out, 16'h0000);
      // any edge restarts: count resumes, then a falling edge restarts it
      second_event_action_in = TCSE_EVB_RESTART_ANY;
      tick(3);
      second_event_input_in = 1'b0;
      tick(4);
      check(counter_value_out, 16'h0001);
      {enable_in, hold, second_event_input_in, first_event_input_enable_in} = '0;
      $display("direction and restart done");
      cmd(TCSE_CMD_RESET);
      split_enable_bit_in = 1'b1;
      wr16(3'h1, 16'h0904);
      wr16(3'h2, 16'h0202);
      wr16(3'h3, 16'h0005);
      wr16(3'h4, 16'h0a05);
      wr16(3'h5, 16'h0101);
      interrupt_enable_in = 5'h1f;
      for (i = 0; i < 3; i++)
         q = {q, 5'h02, i[0] ? 5'h11 : 5'h01};
      {mon_on, enable_in} = 2'b11;
      for (i = 0; i < 60 && q.size() > 0; i++)
      begin
         tick(1);
         wo_acc = wo_acc | waveform_output_out;
      end
      mon_on = 1'b0;
      check(16'(q.size()), 16'h0000);
      check(wo_acc, 6'h09);
      check(irq_out, 5'h13);
      cmd(TCSE_CMD_RESET);
      check(interrupt_flag_out, 5'h13);
      interrupt_enable_in = 5'h01;
      tick(2);
      check(irq_out, 5'h01);
      sleep_mode_in = TCSE_SLEEP_STANDBY;
      tick(2);
      mx = counter_value_out;
      tick(5);
      check(counter_value_out, mx);
      run_in_standby_bit_in = 1'b1;
      tick(3);
      check(16'(counter_value_out != mx), 16'h0001);
      sleep_mode_in = TCSE_SLEEP_ACTIVE;
      cmd(TCSE_CMD_RESTART);
      check(counter_value_out, 16'h0000);
      check(waveform_output_out, 6'h00);
      {enable_in, flag_clear_in} = 6'h1f;
      tick(1);
      flag_clear_in = 5'h00;
      check(irq_out, 5'h00);
      $display("split mode done");
      cmd(TCSE_CMD_RESET);
      {split_enable_bit_in, lock_update_bit_in} = 2'b01;
      wr16(3'h1, 16'h0005);
      wr16(3'h5, 16'h0002);
      cmd(TCSE_CMD_UPDATE);
      {enable_in, mx} = 17'h1_0000;
      for (i = 0; i < 12; i++)
      begin
         tick(1);
         mx = (counter_value_out > mx) ? counter_value_out : mx;
      end
      check(mx, 16'h0002);
      check(interrupt_flag_out, 5'h0f);
      $display("update command done");
      // divide by four after a restart; power-down then stops the count
      prescaler_select_in = 3'h2;
      cmd(TCSE_CMD_RESTART);
      tick(6);
      check(counter_value_out, 16'h0001);
      sleep_mode_in = TCSE_SLEEP_PDOWN;
      tick(2);
      mx = counter_value_out;
      tick(8);
      check(counter_value_out, mx);
      $display("prescaler and power-down done");
      end_sim();
   end
endmodule

// ===== hdl/tcse_pkg.sv
package tcse_pkg;
   // ****************************************************************
   // command codes
   // ****************************************************************
   localparam logic [1:0] TCSE_CMD_NONE = 2'h0;
   localparam logic [1:0] TCSE_CMD_UPDATE = 2'h1;
   localparam logic [1:0] TCSE_CMD_RESTART = 2'h2;
   localparam logic [1:0] TCSE_CMD_RESET = 2'h3;
   // first event input actions
   localparam logic [2:0] TCSE_EVA_POSEDGE = 3'h0;
   localparam logic [2:0] TCSE_EVA_ANYEDGE = 3'h1;
   localparam logic [2:0] TCSE_EVA_HIGHLVL = 3'h2;
   localparam logic [2:0] TCSE_EVA_UPDOWN = 3'h3;
   // second event input actions
   localparam logic [2:0] TCSE_EVB_UPDOWN = 3'h3;
   localparam logic [2:0] TCSE_EVB_RESTART_POS = 3'h4;
   localparam logic [2:0] TCSE_EVB_RESTART_ANY = 3'h5;
   localparam logic [2:0] TCSE_EVB_RESTART_HIGH = 3'h6;
   // sleep states
   localparam logic [1:0] TCSE_SLEEP_ACTIVE = 2'h0;
   localparam logic [1:0] TCSE_SLEEP_IDLE = 2'h1;
   localparam logic [1:0] TCSE_SLEEP_STANDBY = 2'h2;
   localparam logic [1:0] TCSE_SLEEP_PDOWN = 2'h3;
   // reset values
   localparam logic [15:0] TCSE_CNT_RST = 16'h0000;
   localparam logic [15:0] TCSE_PER_RST = 16'hFFFF;
   localparam logic [15:0] TCSE_CMP_RST = 16'h0000;
   localparam logic [3:0] TCSE_FLAG_RST = 4'h0;
   localparam logic [9:0] TCSE_PRE_RST = 10'h000;
   // flag bit positions: 0 ovf/low underflow, 1..3 compare, 4 high underflow
   localparam int TCSE_F_OVF = 0;
   localparam int TCSE_F_CMP0 = 1;
   localparam int TCSE_F_HIGH_UNDERFLOW = 4;
   localparam int TCSE_NFLAG = 5;
endpackage

// ===== hdl/tcse_timer.sv
`timescale 1ns/100ps
module tcse_timer
   import tcse_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   input wire logic enable_in,
   input wire logic split_enable_bit_in,
   input wire logic run_in_standby_bit_in,
   input wire logic [2:0] prescaler_select_in,
   input wire logic lock_update_bit_in,
   input wire logic dir_in,
   input wire logic [1:0] command_in,
   input wire logic command_strobe_in,
   input wire logic [1:0] sleep_mode_in,
   input wire logic wr_strobe_in,
   input wire logic [2:0] wr_sel_in,
   input wire logic wr_hi_byte_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [TCSE_NFLAG-1:0] flag_clear_in,
   input wire logic [TCSE_NFLAG-1:0] interrupt_enable_in,
   input wire logic first_event_input_in,
   input wire logic second_event_input_in,
   input wire logic first_event_input_enable_in,
   input wire logic second_event_input_enable_in,
   input wire logic [2:0] first_event_action_in,
   input wire logic [2:0] second_event_action_in,
   output logic [15:0] counter_value_out,
   output logic [5:0] waveform_output_out,
   output logic [TCSE_NFLAG-1:0] interrupt_flag_out,
   output logic [TCSE_NFLAG-1:0] irq_out,
   output logic overflow_or_low_underflow_event_out,
   output logic high_underflow_out,
   output logic [2:0] compare_match_event_out,
   output logic count_down_out
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [1:0] ev_a_sync;
      logic [1:0] ev_b_sync;
      logic ev_a_prev;
      logic ev_b_prev;
      logic [9:0] pre;
      logic [15:0] cnt;
      logic [15:0] per;
      logic [15:0] perbuf;
      logic [2:0][15:0] cmp;
      logic [2:0][15:0] cmpbuf;
      logic [3:0] bv;
      logic down;
      logic [5:0] wo;
      logic [TCSE_NFLAG-1:0] flag;
      logic [TCSE_NFLAG-1:0] irq;
      logic ovf_ev;
      logic high_underflow_ev;
      logic [2:0] cmp_ev;
   } tcse_state_t;

   tcse_state_t s_q;
   tcse_state_t s_d;

   // prescaler tap for the selected division
   function automatic logic tcse_tick(input logic [9:0] pre, input logic [2:0] sel);
      logic [9:0] mask;
      mask = 10'h000;
      unique case (sel)
         3'h0: mask = 10'h000;
         3'h1: mask = 10'h001;
         3'h2: mask = 10'h003;
         3'h3: mask = 10'h007;
         3'h4: mask = 10'h00F;
         3'h5: mask = 10'h03F;
         3'h6: mask = 10'h0FF;
         3'h7: mask = 10'h3FF;
      endcase
      return (pre & mask) == mask;
   endfunction

   // write one byte into a 16-bit field
   function automatic logic [15:0] tcse_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] data);
      return hi ? {data, old[7:0]} : {old[15:8], data};
   endfunction

   logic running;
   logic tick;
   logic a_lvl;
   logic b_lvl;
   logic a_rise;
   logic a_edge;
   logic b_rise;
   logic b_edge;
   logic do_update;
   logic do_restart;
   logic count_en;
   logic dir_dn;
   logic [15:0] nxt;
   logic at_limit;
   logic [7:0] lc;
   logic [7:0] hc;
   logic [TCSE_NFLAG-1:0] set_f;

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb
   begin
      s_d = s_q;
      set_f = '0;
      s_d.ovf_ev = 1'b0;
      s_d.high_underflow_ev = 1'b0;
      s_d.cmp_ev = 3'h0;
      // standby halts unless the run bit is set; power-down stops all
      running = enable_in && (sleep_mode_in != TCSE_SLEEP_PDOWN) &&
                (sleep_mode_in != TCSE_SLEEP_STANDBY || run_in_standby_bit_in);
      // event inputs come from another domain: two flops first
      s_d.ev_a_sync = {s_q.ev_a_sync[0], first_event_input_in};
      s_d.ev_b_sync = {s_q.ev_b_sync[0], second_event_input_in};
      s_d.ev_a_prev = s_q.ev_a_sync[1];
      s_d.ev_b_prev = s_q.ev_b_sync[1];
      a_lvl = s_q.ev_a_sync[1];
      b_lvl = s_q.ev_b_sync[1];
      a_rise = a_lvl && !s_q.ev_a_prev;
      a_edge = a_lvl != s_q.ev_a_prev;
      b_rise = b_lvl && !s_q.ev_b_prev;
      b_edge = b_lvl != s_q.ev_b_prev;
      tick = tcse_tick(s_q.pre, prescaler_select_in);
      count_en = tick;
      dir_dn = dir_in;
      do_restart = command_strobe_in && command_in == TCSE_CMD_RESTART;
      // events only act in normal mode
      if (!split_enable_bit_in)
      begin
         if (first_event_input_enable_in)
         begin
            unique case (first_event_action_in)
               TCSE_EVA_POSEDGE: count_en = a_rise;
               TCSE_EVA_ANYEDGE: count_en = a_edge;
               TCSE_EVA_HIGHLVL: count_en = tick && a_lvl;
               TCSE_EVA_UPDOWN: dir_dn = a_lvl;
               default: count_en = tick;
            endcase
         end
         if (second_event_input_enable_in)
         begin
            unique case (second_event_action_in)
               TCSE_EVB_UPDOWN: dir_dn = b_lvl;
               TCSE_EVB_RESTART_POS: do_restart = do_restart || b_rise;
               TCSE_EVB_RESTART_ANY: do_restart = do_restart || b_edge;
               TCSE_EVB_RESTART_HIGH: do_restart = do_restart || b_lvl;
               default: do_restart = do_restart;
            endcase
         end
         // both inputs steering direction: up only while both low
         if (first_event_input_enable_in && second_event_input_enable_in &&
             first_event_action_in == TCSE_EVA_UPDOWN &&
             second_event_action_in == TCSE_EVB_UPDOWN)
            dir_dn = a_lvl || b_lvl;
      end
      // a halted timer ignores event restarts; software restart still acts
      if (!running)
         do_restart = command_strobe_in && command_in == TCSE_CMD_RESTART;
      // register writes, byte by byte; contents kept across mode change
      if (wr_strobe_in)
      begin
         unique case (wr_sel_in)
            3'h0: s_d.cnt = tcse_byte(s_q.cnt, wr_hi_byte_in, wr_data_in);
            3'h1: s_d.per = tcse_byte(s_q.per, wr_hi_byte_in, wr_data_in);
            3'h2: s_d.cmp[0] = tcse_byte(s_q.cmp[0], wr_hi_byte_in, wr_data_in);
            3'h3: s_d.cmp[1] = tcse_byte(s_q.cmp[1], wr_hi_byte_in, wr_data_in);
            3'h4: s_d.cmp[2] = tcse_byte(s_q.cmp[2], wr_hi_byte_in, wr_data_in);
            3'h5:
            begin
               s_d.perbuf = tcse_byte(s_q.perbuf, wr_hi_byte_in, wr_data_in);
               s_d.bv[0] = 1'b1;
            end
            3'h6:
            begin
               s_d.cmpbuf[0] = tcse_byte(s_q.cmpbuf[0], wr_hi_byte_in, wr_data_in);
               s_d.bv[1] = 1'b1;
            end
            3'h7:
            begin
               s_d.cmpbuf[1] = tcse_byte(s_q.cmpbuf[1], wr_hi_byte_in, wr_data_in);
               s_d.bv[2] = 1'b1;
            end
         endcase
      end
      lc = s_q.cnt[7:0];
      hc = s_q.cnt[15:8];
      nxt = s_q.cnt;
      at_limit = 1'b0;
      do_update = 1'b0;
      s_d.pre = running ? 10'(s_q.pre + 10'h001) : s_q.pre;
      if (running && count_en && !do_restart)
      begin
         if (split_enable_bit_in)
         begin
            // two independent down-counters, no borrow between bytes
            lc = (lc == 8'h00) ? s_q.per[7:0] : 8'(lc - 8'h01);
            hc = (hc == 8'h00) ? s_q.per[15:8] : 8'(hc - 8'h01);
            s_d.cnt = {hc, lc};
            if (lc == 8'h00)
            begin
               set_f[TCSE_F_OVF] = 1'b1;
            end
            if (hc == 8'h00)
               set_f[TCSE_F_HIGH_UNDERFLOW] = 1'b1;
            for (int i = 0; i < 3; i++)
            begin
               if (lc == 8'h00)
                  s_d.wo[i] = 1'b0;
               else if (lc == s_q.cmp[i][7:0] && s_q.cmp[i][7:0] <= s_q.per[7:0])
                  s_d.wo[i] = 1'b1;
               if (hc == 8'h00)
                  s_d.wo[i+3] = 1'b0;
               else if (hc == s_q.cmp[i][15:8] && s_q.cmp[i][15:8] <= s_q.per[15:8])
                  s_d.wo[i+3] = 1'b1;
               if (lc == s_q.cmp[i][7:0])
                  set_f[TCSE_F_CMP0+i] = 1'b1;
            end
         end
         else
         begin
            // normal single-slope-style up or down count between bottom and top
            if (dir_dn)
            begin
               at_limit = s_q.cnt == 16'h0000;
               nxt = at_limit ? s_q.per : 16'(s_q.cnt - 16'h0001);
            end
            else
            begin
               at_limit = s_q.cnt == s_q.per;
               nxt = at_limit ? 16'h0000 : 16'(s_q.cnt + 16'h0001);
            end
            s_d.cnt = nxt;
            set_f[TCSE_F_OVF] = at_limit;
            do_update = at_limit && !lock_update_bit_in;
            for (int i = 0; i < 3; i++)
            begin
               if (nxt == s_q.cmp[i])
               begin
                  set_f[TCSE_F_CMP0+i] = 1'b1;
                  s_d.wo[i] = 1'b0;
               end
               if (nxt == 16'h0000 && s_q.cmp[i] != 16'h0000)
                  s_d.wo[i] = 1'b1;
            end
         end
      end
      // update command bypasses the lock bit
      if (command_strobe_in && command_in == TCSE_CMD_UPDATE)
         do_update = 1'b1;
      // buffers move only in normal mode
      if (do_update && !split_enable_bit_in)
      begin
         if (s_q.bv[0])
            s_d.per = s_q.perbuf;
         for (int i = 0; i < 2; i++)
         begin
            if (s_q.bv[i+1])
               s_d.cmp[i] = s_q.cmpbuf[i];
         end
         s_d.bv = 4'h0;
      end
      if (do_restart)
      begin
         s_d.cnt = TCSE_CNT_RST;
         s_d.wo = 6'h00;
         s_d.pre = TCSE_PRE_RST;
      end
      // events pulse for one cycle exactly when their flag is raised
      s_d.ovf_ev = set_f[TCSE_F_OVF];
      s_d.cmp_ev = set_f[TCSE_F_CMP0 +: 3];
      s_d.high_underflow_ev = set_f[TCSE_F_HIGH_UNDERFLOW] && split_enable_bit_in;
      // set wins over clear
      s_d.flag = (s_q.flag & ~flag_clear_in) | set_f;
      s_d.down = split_enable_bit_in ? 1'b1 : dir_dn;
      // reset command honoured only while disabled
      if (command_strobe_in && command_in == TCSE_CMD_RESET && !enable_in)
      begin
         s_d.pre = TCSE_PRE_RST;
         s_d.cnt = TCSE_CNT_RST;
         s_d.per = TCSE_PER_RST;
         s_d.perbuf = TCSE_PER_RST;
         s_d.cmp = {3{TCSE_CMP_RST}};
         s_d.cmpbuf = {3{TCSE_CMP_RST}};
         s_d.bv = TCSE_FLAG_RST;
         s_d.wo = 6'h00;
         s_d.flag = '0;
         s_d.down = 1'b0;
      end
      s_d.irq = s_d.flag & interrupt_enable_in;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
         s_q.per <= TCSE_PER_RST;
         s_q.perbuf <= TCSE_PER_RST;
      end
      else if (clk_en_in)
         s_q <= s_d;
   end

   // outputs straight from flops
   assign counter_value_out = s_q.cnt;
   assign waveform_output_out = s_q.wo;
   assign interrupt_flag_out = s_q.flag;
   assign irq_out = s_q.irq;
   assign overflow_or_low_underflow_event_out = s_q.ovf_ev;
   assign high_underflow_out = s_q.high_underflow_ev;
   assign compare_match_event_out = s_q.cmp_ev;
   assign count_down_out = s_q.down;
endmodule
